//--- lcdc_decoder.sv
// Configuration command decoder of a dot-matrix LCD driver.
// Assumes host parallel-port pins are asynchronous and held steady
// for at least three clocks around the rising edge of the write strobe.
//
// Function
// - End command leaves read-modify-write and restores the saved column.
// - Soft reset restores line, column, page, scan, ratio, contrast, indicator.
// - Byte E2 with select low is soft reset, done after acceptance.
// - Bytes 1100dxxx set row scan direction from bit 3.
// - Bytes 00101bcd switch booster, regulator and follower.
// - Bytes 00100xxx load a three-bit divider ratio.
// - Byte 81 enters contrast mode; next byte is only contrast value.
// - Following byte loads six contrast bits and ends contrast mode.
// - Bytes 1010110x turn indicator off, or on awaiting a register byte.
// - After indicator on, only the register byte is accepted.
// - Indicator register takes bits 1:0: off, slow, fast, steady.
// - Only indicator commands, soft reset and the clear pin change the indicator state.
// - Indicator drives alternation phase and static segment outputs.
// - During a soft reset or pin clear the status shows busy and reset bits.
// - Test mode 1111xxxx is cleared by pin, soft reset or no-op.
`timescale 1ns/1ns
`default_nettype none
module lcdc_decoder
	import lcdc_pkg::*;
#(
	parameter int SLOW_CYC = BLINK1_CYC,
	parameter int FAST_CYC = BLINK05_CYC,
	parameter int FR_CYC   = FR_HALF_CYC
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Host parallel port pins
	input  wire logic             power_on_clear_pin_n,
	input  wire logic             wr_strobe_pin,
	input  wire logic             cmd_data_select,
	input  wire logic [7:0]       data_pin,
	// Column address logic
	input  wire logic [7:0]       col_addr_in,
	output logic                  col_restore,
	output logic [7:0]            col_restore_val,
	output logic                  addr_reset,
	// Settings and state
	output lcdc_pkg::lcdc_cfg_t   cfg,
	output logic                  rmw_active,
	output logic                  test_active,
	output logic [7:0]            status,
	// Indicator electrodes
	output logic                  alternation_phase_out,
	output logic                  static_segment_out
);
	// ==========================================================
	// Pin synchronisers
	logic [9:0]  sync1_r, sync2_r;
	logic        wr_d_r, pin_clr1_r, pin_clr2_r;
	logic        wr_edge, a0, hw_clr;
	logic [7:0]  byte_in;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_r    <= 10'h000;
			sync2_r    <= 10'h000;
			wr_d_r     <= 1'b0;
			pin_clr1_r <= 1'b0;
			pin_clr2_r <= 1'b0;
		end else begin
			sync1_r    <= {wr_strobe_pin, cmd_data_select, data_pin};
			sync2_r    <= sync1_r;
			wr_d_r     <= sync2_r[9];
			pin_clr1_r <= ~power_on_clear_pin_n;
			pin_clr2_r <= pin_clr1_r;
		end
	end

	assign wr_edge = sync2_r[9] & ~wr_d_r;
	assign a0      = sync2_r[8];
	assign byte_in = sync2_r[7:0];
	assign hw_clr  = pin_clr2_r;

	function automatic logic is_cmd(input logic [7:0] b,
		input logic [7:0] code, input logic [7:0] msk);
		return (b & msk) == code;
	endfunction

	// ==========================================================
	// Decoder state
	lcdc_state_t st_r, st_nxt;
	lcdc_cfg_t   cfg_nxt;
	logic        rmw_nxt, test_nxt;
	logic [7:0]  col_save_r, col_save_nxt;
	logic        rst_req_r, rst_req_nxt;
	logic [7:0]  rst_cnt_r, rst_cnt_nxt;
	logic        busy;
	logic        col_restore_nxt, addr_reset_nxt;
	logic        accept;

	assign busy   = (rst_cnt_r != 8'h00) | hw_clr;
	// Writes during a reset are dropped, as the busy flag warns
	assign accept = wr_edge & ~a0 & ~busy;

	always_comb begin
		st_nxt          = st_r;
		cfg_nxt         = cfg;
		rmw_nxt         = rmw_active;
		test_nxt        = test_active;
		col_save_nxt    = col_save_r;
		rst_req_nxt     = 1'b0;
		rst_cnt_nxt     = rst_cnt_r;
		col_restore_nxt = 1'b0;
		addr_reset_nxt  = 1'b0;
		if (rst_cnt_r != 8'h00)
			rst_cnt_nxt = rst_cnt_r - 8'h01;
		if (hw_clr) begin
			// Pin holds settings, state and modes cleared, power circuits included; saved column kept
			st_nxt         = LCDC_ST_CMD;
			cfg_nxt        = CFG_RST;
			rmw_nxt        = 1'b0;
			test_nxt       = 1'b0;
			addr_reset_nxt = 1'b1;
			rst_cnt_nxt    = 8'(RESET_CYC);
		end else if (rst_req_r) begin
			// Soft reset runs the cycle after the byte was taken
			st_nxt                = LCDC_ST_CMD;
			cfg_nxt.scan_desc     = 1'b0;
			cfg_nxt.divider_ratio = RATIO_RST;
			cfg_nxt.contrast      = CONTRAST_RST;
			cfg_nxt.ind_on        = 1'b0;
			cfg_nxt.ind_mode      = IND_OFF;
			rmw_nxt               = 1'b0;
			test_nxt              = 1'b0;
			addr_reset_nxt        = 1'b1;
		end else if (accept) begin
			case (st_r)
				LCDC_ST_CONTRAST: begin
					cfg_nxt.contrast = byte_in[5:0];
					st_nxt           = LCDC_ST_CMD;
				end
				LCDC_ST_INDIC: begin
					cfg_nxt.ind_mode = byte_in[1:0];
					st_nxt           = LCDC_ST_CMD;
				end
				LCDC_ST_CMD: begin
					if (byte_in == CMD_RESET) begin
						rst_req_nxt = 1'b1;
						rst_cnt_nxt = 8'(RESET_CYC);
					end else if (byte_in == CMD_NOP) begin
						test_nxt = 1'b0;
					end else if (byte_in == CMD_RMW) begin
						rmw_nxt      = 1'b1;
						col_save_nxt = col_addr_in;
					end else if (byte_in == CMD_END) begin
						// Restore only when the mode was really entered
						col_restore_nxt = rmw_active;
						rmw_nxt         = 1'b0;
					end else if (byte_in == CMD_CONTRAST) begin
						st_nxt = LCDC_ST_CONTRAST;
					end else if (is_cmd(byte_in, CMD_IND, MSK_IND)) begin
						cfg_nxt.ind_on = byte_in[IND_BIT];
						if (byte_in[IND_BIT])
							st_nxt = LCDC_ST_INDIC;
					end else if (is_cmd(byte_in, CMD_SCAN, MSK_SCAN)) begin
						cfg_nxt.scan_desc = byte_in[SCAN_BIT];
					end else if (is_cmd(byte_in, CMD_POWER, MSK_POWER)) begin
						cfg_nxt.booster_on   = byte_in[BOOST_BIT];
						cfg_nxt.regulator_on = byte_in[REGUL_BIT];
						cfg_nxt.follower_on  = byte_in[FOLLW_BIT];
					end else if (is_cmd(byte_in, CMD_RATIO, MSK_RATIO)) begin
						cfg_nxt.divider_ratio = byte_in[2:0];
					end else if (is_cmd(byte_in, CMD_TEST, MSK_TEST)) begin
						test_nxt = 1'b1;
					end
				end
				default: st_nxt = LCDC_ST_CMD;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r            <= LCDC_ST_CMD;
			cfg             <= CFG_RST;
			rmw_active      <= 1'b0;
			test_active     <= 1'b0;
			col_save_r      <= COL_RST;
			rst_req_r       <= 1'b0;
			rst_cnt_r       <= 8'h00;
			col_restore     <= 1'b0;
			col_restore_val <= COL_RST;
			addr_reset      <= 1'b0;
			status          <= 8'h00;
		end else begin
			st_r            <= st_nxt;
			cfg             <= cfg_nxt;
			rmw_active      <= rmw_nxt;
			test_active     <= test_nxt;
			col_save_r      <= col_save_nxt;
			rst_req_r       <= rst_req_nxt;
			rst_cnt_r       <= rst_cnt_nxt;
			col_restore     <= col_restore_nxt;
			col_restore_val <= col_save_nxt;
			addr_reset      <= addr_reset_nxt;
			status          <= 8'h00;
			status[STAT_BUSY] <= (rst_cnt_nxt != 8'h00) | hw_clr;
			status[STAT_RST]  <= (rst_cnt_nxt != 8'h00) | hw_clr;
		end
	end

	// ==========================================================
	// Indicator drive
	lcdc_indicator #(
		.SLOW_CYC (SLOW_CYC),
		.FAST_CYC (FAST_CYC),
		.FR_CYC   (FR_CYC)
	) u_ind (
		.clk                   (clk),
		.rst_n                 (rst_n),
		.ind_on                (cfg.ind_on),
		.ind_mode              (cfg.ind_mode),
		.alternation_phase_out (alternation_phase_out),
		.static_segment_out    (static_segment_out)
	);

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_end_restore: assert property (
		accept && st_r == LCDC_ST_CMD && byte_in == CMD_END && rmw_active
		|=> col_restore && !rmw_active && col_restore_val == $past(col_save_r))
		else $error("end did not restore column");
	chk_soft_reset: assert property (
		accept && st_r == LCDC_ST_CMD && byte_in == CMD_RESET && !hw_clr
		|=> ##1 addr_reset && cfg.contrast == CONTRAST_RST && !cfg.ind_on
		&& !test_active && !rmw_active)
		else $error("soft reset did not clear settings");
	chk_rst_busy: assert property (
		accept && st_r == LCDC_ST_CMD && byte_in == CMD_RESET
		|=> status[STAT_BUSY] && status[STAT_RST])
		else $error("reset not flagged busy");
	chk_scan_dir: assert property (
		accept && st_r == LCDC_ST_CMD && is_cmd(byte_in, CMD_SCAN, MSK_SCAN)
		&& !rst_req_r |=> cfg.scan_desc == $past(byte_in[SCAN_BIT]))
		else $error("scan direction not loaded");
	chk_power_bits: assert property (
		accept && st_r == LCDC_ST_CMD
		&& is_cmd(byte_in, CMD_POWER, MSK_POWER) && !rst_req_r
		|=> {cfg.booster_on, cfg.regulator_on, cfg.follower_on}
		== $past(byte_in[2:0]))
		else $error("power enables not loaded");
	chk_ratio_load: assert property (
		accept && st_r == LCDC_ST_CMD
		&& is_cmd(byte_in, CMD_RATIO, MSK_RATIO) && !rst_req_r
		|=> cfg.divider_ratio == $past(byte_in[2:0]))
		else $error("divider ratio not loaded");
	chk_contrast_seq: assert property (
		st_r == LCDC_ST_CONTRAST && accept && !rst_req_r && !hw_clr
		|=> cfg.contrast == $past(byte_in[5:0]) && st_r == LCDC_ST_CMD
		&& $stable(cfg.scan_desc) && $stable(test_active))
		else $error("contrast byte mishandled");
	chk_ind_seq: assert property (
		st_r == LCDC_ST_INDIC && accept && !rst_req_r && !hw_clr
		|=> cfg.ind_mode == $past(byte_in[1:0]) && st_r == LCDC_ST_CMD
		&& $stable(cfg.contrast))
		else $error("indicator byte mishandled");
	chk_ind_only: assert property (
		!(accept && (st_r == LCDC_ST_INDIC
		|| is_cmd(byte_in, CMD_IND, MSK_IND))) && !rst_req_r && !hw_clr
		|=> $stable(cfg.ind_on) && $stable(cfg.ind_mode))
		else $error("indicator changed by other command");
	chk_test_clear: assert property (
		accept && st_r == LCDC_ST_CMD && byte_in == CMD_NOP && !rst_req_r
		|=> !test_active)
		else $error("no-op did not clear test mode");
	chk_data_ignored: assert property (
		wr_edge && a0 && !rst_req_r && !hw_clr
		|=> $stable(cfg) && $stable(st_r))
		else $error("data write decoded as command");

	cov_contrast: cover property (st_r == LCDC_ST_CONTRAST ##[1:20]
		st_r == LCDC_ST_CMD);
	cov_ind_on: cover property (st_r == LCDC_ST_INDIC ##[1:20]
		cfg.ind_on && cfg.ind_mode == IND_FAST);
	cov_rmw_end: cover property (col_restore);
	cov_soft_rst: cover property (rst_req_r);

endmodule // lcdc_decoder
`default_nettype wire

//--- lcdc_decoder_test.sv
// Self-checking bench of the LCD configuration command decoder.
// Assumes lcdc_pkg and lcdc_host; short blink counts for simulation.
`timescale 1ns/1ns
`default_nettype none
module lcdc_decoder_test;
	import lcdc_pkg::*;

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        power_on_clear_pin_n;
	logic        wr_strobe_pin;
	logic        cmd_data_select;
	logic [7:0]  data_pin;
	logic [7:0]  col_addr_in = 8'h00;
	logic        col_restore;
	logic [7:0]  col_restore_val;
	logic        addr_reset;
	lcdc_cfg_t   cfg;
	lcdc_cfg_t   exp;
	logic        rmw_active;
	logic        test_active;
	logic [7:0]  status;
	logic        alternation_phase_out;
	logic        static_segment_out;
	int          bad_count = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          restore_cnt = 0;
	int          areset_cnt = 0;
	int          restore_base = 0;
	int          areset_base = 0;

	always #5 clk = ~clk;

	lcdc_host u_lcdc_host (
		.clk                  (clk),
		.power_on_clear_pin_n (power_on_clear_pin_n),
		.wr_strobe_pin        (wr_strobe_pin),
		.cmd_data_select      (cmd_data_select),
		.data_pin             (data_pin)
	);

	lcdc_decoder #(.SLOW_CYC(8), .FAST_CYC(4), .FR_CYC(2)) u_lcdc_decoder (
		.clk                   (clk),
		.rst_n                 (rst_n),
		.power_on_clear_pin_n  (power_on_clear_pin_n),
		.wr_strobe_pin         (wr_strobe_pin),
		.cmd_data_select       (cmd_data_select),
		.data_pin              (data_pin),
		.col_addr_in           (col_addr_in),
		.col_restore           (col_restore),
		.col_restore_val       (col_restore_val),
		.addr_reset            (addr_reset),
		.cfg                   (cfg),
		.rmw_active            (rmw_active),
		.test_active           (test_active),
		.status                (status),
		.alternation_phase_out (alternation_phase_out),
		.static_segment_out    (static_segment_out)
	);

	// ==========================================================
	// Pulse monitors and hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (col_restore === 1'b1)
			restore_cnt <= restore_cnt + 1;
		if (addr_reset === 1'b1)
			areset_cnt <= areset_cnt + 1;
		if (cycles == 20000) begin
			bad_count = bad_count + 1;
			test_done();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] want);
		#1;
		samples_checked = samples_checked + 1;
		if (got !== want) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, want);
			bad_count = bad_count + 1;
		end
	endtask

	task automatic cmd(input logic [7:0] d);
		u_lcdc_host.write(1'b0, d);
	endtask

	// Busy is bounded well above the hundred-cycle reset time
	task automatic wait_idle();
		int n;
		n = 0;
		while (status[STAT_BUSY] !== 1'b0 && n < 300) begin
			@(negedge clk);
			n = n + 1;
		end
		check(16'(n < 300), 16'h0001);
	endtask

	// Lit electrodes run in antiphase, dark ones in phase
	task automatic seg_check(input logic lit);
		logic prev;
		int   flips;
		flips = 0;
		@(negedge clk);
		prev = alternation_phase_out;
		repeat (16) begin
			@(negedge clk);
			if (alternation_phase_out !== prev)
				flips = flips + 1;
			prev = alternation_phase_out;
			check(static_segment_out, alternation_phase_out ^ lit);
		end
		check(16'(flips), 16'h0008);
	endtask

	// Blink shows as segment-to-phase toggles at the blink half-period
	task automatic blink_check(input int want);
		logic prev;
		int   n;
		n = 0;
		@(negedge clk);
		prev = static_segment_out ^ alternation_phase_out;
		repeat (16) begin
			@(negedge clk);
			if ((static_segment_out ^ alternation_phase_out) !== prev)
				n = n + 1;
			prev = static_segment_out ^ alternation_phase_out;
		end
		check(16'(n), 16'(want));
	endtask

	// ==========================================================
	// Test sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		check(cfg, CFG_RST);
		fork
			u_lcdc_host.hw_clear(8);
			begin
				repeat (6) @(posedge clk);
				check(status, 8'h90);
			end
		join
		wait_idle();
		check(cfg, CFG_RST);
		check(16'(areset_cnt > 0), 16'h0001);
		// Scan direction, data bytes never decoded
		cmd(8'hCF);
		check(cfg.scan_desc, 1'b1);
		cmd(8'hC7);
		check(cfg.scan_desc, 1'b0);
		u_lcdc_host.write(1'b1, 8'hCF);
		check(cfg.scan_desc, 1'b0);
		for (int i = 0; i < 8; i++) begin
			cmd(8'h28 | 8'(i));
			check({cfg.booster_on, cfg.regulator_on, cfg.follower_on},
				16'(i));
			cmd(8'h20 | 8'(i));
			check(cfg.divider_ratio, 16'(i));
		end
		// Contrast: command byte in value slot is the value
		cmd(CMD_CONTRAST);
		cmd(CMD_RESET);
		check(cfg.contrast, 6'h22);
		check(status, 8'h00);
		cmd(CMD_CONTRAST);
		u_lcdc_host.write(1'b1, 8'h3F);
		cmd(8'hD5);
		check(cfg.contrast, 6'h15);
		u_lcdc_host.contrast_default();
		check(cfg.contrast, 6'h20);
		// Indicator modes, then an off byte taken as register value
		for (int m = 0; m < 4; m++) begin
			cmd(8'hAD);
			cmd(8'hFC | 8'(m));
			check({cfg.ind_on, cfg.ind_mode}, 3'h4 | 3'(m));
			if (m == 1 || m == 2) blink_check(m == 1 ? 2 : 4);
		end
		cmd(8'hAD);
		cmd(8'hAC);
		check({cfg.ind_on, cfg.ind_mode}, 3'h4);
		cmd(8'hAD);
		cmd(8'h03);
		seg_check(1'b1);
		cmd(8'hAC);
		check({cfg.ind_on, cfg.ind_mode}, 3'h3);
		seg_check(1'b0);
		cmd(8'hC8);
		cmd(CMD_NOP);
		cmd(8'h2F);
		check({cfg.ind_on, cfg.ind_mode}, 3'h3);
		// Read-modify-write saves and restores the column
		@(posedge clk) col_addr_in <= 8'h5A;
		cmd(CMD_RMW);
		check(rmw_active, 1'b1);
		@(posedge clk) col_addr_in <= 8'h77;
		restore_base = restore_cnt;
		cmd(CMD_END);
		check({8'(restore_cnt - restore_base), col_restore_val},
			16'h015A);
		check(rmw_active, 1'b0);
		// Test mode cleared by no-op
		cmd(8'hF5);
		check(test_active, 1'b1);
		cmd(CMD_NOP);
		check(test_active, 1'b0);
		// Soft reset from a busy configuration
		cmd(8'hF0);
		cmd(8'hAD);
		cmd(8'h02);
		cmd(8'h25);
		cmd(CMD_RMW);
		areset_base = areset_cnt;
		cmd(CMD_RESET);
		check(status, 8'h90);
		cmd(8'hC8);
		wait_idle();
		exp = CFG_RST;
		exp.booster_on   = 1'b1;
		exp.regulator_on = 1'b1;
		exp.follower_on  = 1'b1;
		check(cfg, exp);
		check({test_active, rmw_active}, 2'h0);
		check(16'(areset_cnt - areset_base), 16'h0001);
		// Hardware clear also ends test mode
		cmd(8'hF0);
		u_lcdc_host.hw_clear(4);
		wait_idle();
		check(test_active, 1'b0);
		test_done();
	end
endmodule // lcdc_decoder_test
`default_nettype wire

//--- lcdc_host.sv
// Host processor model: writes bytes over the parallel port, drives clear pin.
// Assumes the decoder samples its pins on the rising edge of clk.
`timescale 1ns/1ns
`default_nettype none
module lcdc_host (
	// Clock
	input  wire logic       clk,
	// Parallel port
	output var logic        power_on_clear_pin_n,
	output var logic        wr_strobe_pin,
	output var logic        cmd_data_select,
	output var logic [7:0]  data_pin
);
	initial begin
		power_on_clear_pin_n = 1'b1;
		wr_strobe_pin        = 1'b0;
		cmd_data_select      = 1'b1;
		data_pin             = 8'h00;
	end

	// ==========================================================
	// Bus cycles
	// Pins steady three clocks around the strobe rise, since they are synced
	task automatic write(input logic sel, input logic [7:0] d);
		@(posedge clk);
		cmd_data_select <= sel;
		data_pin        <= d;
		repeat (3) @(posedge clk);
		wr_strobe_pin <= 1'b1;
		repeat (4) @(posedge clk);
		wr_strobe_pin <= 1'b0;
		repeat (3) @(posedge clk);
		// Released bus: never leave the last value showing
		data_pin        <= ~d;
		cmd_data_select <= ~sel;
	endtask

	task automatic hw_clear(input int n);
		@(posedge clk);
		power_on_clear_pin_n <= 1'b0;
		repeat (n) @(posedge clk);
		power_on_clear_pin_n <= 1'b1;
	endtask

	// Mode byte and value back to back, neutral level when unadjusted
	task automatic contrast_default();
		write(1'b0, 8'h81);
		write(1'b0, 8'h20);
	endtask
endmodule // lcdc_host
`default_nettype wire

//--- lcdc_indicator.sv
// Static indicator drive: alternation phase and static segment outputs.
// Assumes on/mode come from flops on the same clock.
`timescale 1ns/1ns
`default_nettype none
module lcdc_indicator
	import lcdc_pkg::*;
#(
	parameter int SLOW_CYC = BLINK1_CYC,
	parameter int FAST_CYC = BLINK05_CYC,
	parameter int FR_CYC   = FR_HALF_CYC
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Indicator setting
	input  wire logic       ind_on,
	input  wire logic [1:0] ind_mode,
	// Electrodes
	output logic            alternation_phase_out,
	output logic            static_segment_out
);
	logic [31:0] fr_cnt_r, fr_cnt_nxt, bl_cnt_r, bl_cnt_nxt;
	logic        fr_r, fr_nxt, blink_r, blink_nxt, seg_nxt;
	logic [31:0] bl_lim;

	// ==========================================================
	// Phase and blink timers
	always_comb begin
		bl_lim     = (ind_mode == IND_FAST) ? FAST_CYC : SLOW_CYC;
		fr_cnt_nxt = fr_cnt_r + 32'h1;
		fr_nxt     = fr_r;
		if (fr_cnt_r >= FR_CYC - 1) begin
			fr_cnt_nxt = 32'h0;
			fr_nxt     = ~fr_r;
		end
		bl_cnt_nxt = bl_cnt_r + 32'h1;
		blink_nxt  = blink_r;
		if (bl_cnt_r >= bl_lim - 1) begin
			bl_cnt_nxt = 32'h0;
			blink_nxt  = ~blink_r;
		end
		// Lit segment is driven in antiphase to the common electrode
		case (ind_mode)
			IND_SLOW, IND_FAST: seg_nxt = fr_nxt ^ (ind_on & blink_nxt);
			IND_STEADY:         seg_nxt = fr_nxt ^ ind_on;
			default:            seg_nxt = fr_nxt;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fr_cnt_r              <= 32'h0;
			bl_cnt_r              <= 32'h0;
			fr_r                  <= 1'b0;
			blink_r               <= 1'b0;
			alternation_phase_out <= 1'b0;
			static_segment_out    <= 1'b0;
		end else begin
			fr_cnt_r              <= fr_cnt_nxt;
			bl_cnt_r              <= bl_cnt_nxt;
			fr_r                  <= fr_nxt;
			blink_r               <= blink_nxt;
			alternation_phase_out <= fr_nxt;
			static_segment_out    <= seg_nxt;
		end
	end

	chk_off_in_phase: assert property (@(posedge clk) disable iff (!rst_n)
		!ind_on && $past(!ind_on) |=> static_segment_out == alternation_phase_out)
		else $error("indicator off but segment not in phase");

endmodule // lcdc_indicator
`default_nettype wire

//--- lcdc_pkg.sv
// Constants, command codes and carrier types of the LCD config decoder.
// Assumes a 100 MHz system clock; shared by decoder and indicator driver.
package lcdc_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_NS      = 10;
	localparam int RESET_NS    = 1000;
	localparam int RESET_CYC   = (RESET_NS + CLK_NS - 1) / CLK_NS;
	localparam int BLINK1_MS   = 1000;
	localparam int BLINK05_MS  = 500;
	localparam int FRAME_US    = 10000;
	localparam int BLINK1_CYC  = (BLINK1_MS * 1000 / CLK_NS) * 1000;
	localparam int BLINK05_CYC = (BLINK05_MS * 1000 / CLK_NS) * 1000;
	localparam int FR_HALF_CYC = (FRAME_US * 1000) / CLK_NS / 2;

	// ==========================================================
	// Command codes and masks
	localparam logic [7:0] CMD_RMW      = 8'hE0;
	localparam logic [7:0] CMD_END      = 8'hEE;
	localparam logic [7:0] CMD_RESET    = 8'hE2;
	localparam logic [7:0] CMD_NOP      = 8'hE3;
	localparam logic [7:0] CMD_CONTRAST = 8'h81;
	localparam logic [7:0] CMD_SCAN     = 8'hC0;
	localparam logic [7:0] MSK_SCAN     = 8'hF0;
	localparam logic [7:0] CMD_POWER    = 8'h28;
	localparam logic [7:0] MSK_POWER    = 8'hF8;
	localparam logic [7:0] CMD_RATIO    = 8'h20;
	localparam logic [7:0] MSK_RATIO    = 8'hF8;
	localparam logic [7:0] CMD_IND      = 8'hAC;
	localparam logic [7:0] MSK_IND      = 8'hFE;
	localparam logic [7:0] CMD_TEST     = 8'hF0;
	localparam logic [7:0] MSK_TEST     = 8'hF0;

	// ==========================================================
	// Field positions
	localparam int SCAN_BIT  = 3;
	localparam int BOOST_BIT = 2;
	localparam int REGUL_BIT = 1;
	localparam int FOLLW_BIT = 0;
	localparam int IND_BIT   = 0;
	localparam int STAT_BUSY = 7;
	localparam int STAT_RST  = 4;

	// ==========================================================
	// Reset values and indicator modes
	localparam logic [5:0] CONTRAST_RST = 6'h00;
	localparam logic [2:0] RATIO_RST    = 3'h0;
	localparam logic [7:0] COL_RST      = 8'h00;
	localparam logic [1:0] IND_OFF      = 2'h0;
	localparam logic [1:0] IND_SLOW     = 2'h1;
	localparam logic [1:0] IND_FAST     = 2'h2;
	localparam logic [1:0] IND_STEADY   = 2'h3;

	typedef enum logic [1:0] {
		LCDC_ST_CMD      = 2'b00,
		LCDC_ST_CONTRAST = 2'b01,
		LCDC_ST_INDIC    = 2'b10
	} lcdc_state_t;

	typedef struct packed {
		logic       scan_desc;
		logic       booster_on;
		logic       regulator_on;
		logic       follower_on;
		logic [2:0] divider_ratio;
		logic [5:0] contrast;
		logic       ind_on;
		logic [1:0] ind_mode;
	} lcdc_cfg_t;

	localparam lcdc_cfg_t CFG_RST = '{
		scan_desc: 1'b0, booster_on: 1'b0, regulator_on: 1'b0,
		follower_on: 1'b0, divider_ratio: RATIO_RST,
		contrast: CONTRAST_RST, ind_on: 1'b0, ind_mode: IND_OFF};

endpackage
